// >>> sadc_pkg.sv
package sadc_pkg;
   // ---------------------------------------------
   // sizes
   // ---------------------------------------------
   localparam int RES_W = 10;
   localparam int CH_N  = 10;

   // ---------------------------------------------
   // operating modes
   // ---------------------------------------------
   typedef enum logic [2:0] {
      sadc_one_shot = 3'h0,
      sadc_repeat   = 3'h1,
      sadc_sweep    = 3'h2,
      sadc_rsweep0  = 3'h3,
      sadc_rsweep1  = 3'h4
   } sadc_mode_t;

   // ---------------------------------------------
   // conversion lengths in converter clock cycles
   // ---------------------------------------------
   localparam logic [6:0] CYC_8_PLAIN  = 7'h31;
   localparam logic [6:0] CYC_10_PLAIN = 7'h3B;
   localparam logic [6:0] CYC_8_SH     = 7'h1C;
   localparam logic [6:0] CYC_10_SH    = 7'h21;
   localparam logic [6:0] BITS_8       = 7'h08;
   localparam logic [6:0] BITS_10      = 7'h0A;
   localparam logic [9:0] SAR_MSB      = 10'h200;

   // ---------------------------------------------
   // clock divider select and channel indices
   // ---------------------------------------------
   localparam logic [1:0] DIV_1    = 2'h0;
   localparam logic [1:0] DIV_2    = 2'h1;
   localparam logic [1:0] DIV_4    = 2'h2;
   localparam logic [1:0] EXT_NONE = 2'h0;
   localparam logic [1:0] EXT_A    = 2'h1;
   localparam logic [1:0] EXT_B    = 2'h2;
   localparam logic [3:0] CH_EXT_A = 4'h8;
   localparam logic [3:0] CH_EXT_B = 4'h9;
endpackage : sadc_pkg

// >>> sadc_sar_core.sv
module sadc_sar_core (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       phi_tick,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic       prec_10bit,
   input  wire logic       sample_hold_en,
   input  wire logic       cmp_above,
   output logic [9:0]      dac_code,
   output logic            busy,
   output logic            sampling,
   output logic            done,
   output logic [9:0]      result
);
   logic [6:0] cnt_ff;
   logic [6:0] len_ff;
   logic [6:0] nbits_ff;
   logic [9:0] sar_ff;
   logic [9:0] bit_ff;
   logic       busy_ff;
   logic       done_ff;
   logic [9:0] res_ff;
   logic [6:0] tick_ff;
   logic [6:0] nxt_len;
   logic [9:0] nxt_sar;
   logic       deciding;

   // ---------------------------------------------
   // length of one channel conversion
   // ---------------------------------------------
   always_comb begin
      if (sample_hold_en) begin
         nxt_len = prec_10bit ? sadc_pkg::CYC_10_SH : sadc_pkg::CYC_8_SH;
      end else begin
         nxt_len = prec_10bit ? sadc_pkg::CYC_10_PLAIN : sadc_pkg::CYC_8_PLAIN;
      end
   end

   // one decision per tick, msb first; 8-bit uses the top eight bits
   assign deciding = busy_ff && phi_tick && (cnt_ff <= nbits_ff);
   assign nxt_sar  = ((cmp_above ? sar_ff : (sar_ff & ~bit_ff)) | (bit_ff >> 1));

   // ---------------------------------------------
   // approximation register and counter
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst || abort) begin
         busy_ff <= 1'b0;
         cnt_ff  <= 7'h00;
         sar_ff  <= sadc_pkg::SAR_MSB;
         bit_ff  <= sadc_pkg::SAR_MSB;
      end else if (start) begin
         busy_ff  <= 1'b1;
         cnt_ff   <= nxt_len;
         len_ff   <= nxt_len;
         nbits_ff <= prec_10bit ? sadc_pkg::BITS_10 : sadc_pkg::BITS_8;
         sar_ff   <= sadc_pkg::SAR_MSB;
         bit_ff   <= sadc_pkg::SAR_MSB;
      end else if (busy_ff && phi_tick) begin
         cnt_ff <= cnt_ff - 7'h01;
         if (deciding) begin
            sar_ff <= nxt_sar;
            bit_ff <= bit_ff >> 1;
         end
         if (cnt_ff == 7'h01) begin
            busy_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         done_ff <= 1'b0;
         res_ff  <= 10'h000;
      end else begin
         done_ff <= !abort && !start && busy_ff && phi_tick && (cnt_ff == 7'h01);
         if (!abort && !start && busy_ff && phi_tick && (cnt_ff == 7'h01)) begin
            res_ff <= (nbits_ff == sadc_pkg::BITS_10) ? nxt_sar : {2'h0, nxt_sar[9:2]};
         end
      end
   end

   assign dac_code = sar_ff;
   assign busy     = busy_ff;
   assign sampling = busy_ff && (cnt_ff > nbits_ff);
   assign done     = done_ff;
   assign result   = res_ff;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst || abort || start) begin
         tick_ff <= 7'h00;
      end else if (busy_ff && phi_tick) begin
         tick_ff <= tick_ff + 7'h01;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_conv_length: assert property (done |-> tick_ff == len_ff)
      else $error("conversion length differs from the selected figure");
   chk_core_idle: assert property (done |-> !busy_ff)
      else $error("converter still busy after its result");
endmodule : sadc_sar_core

// >>> sadc_sequencer.sv
module sadc_sequencer #(
   parameter int CH_N = sadc_pkg::CH_N
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       start_wr,
   input  wire logic       start_wdata,
   input  wire logic [2:0] mode_sel,
   input  wire logic       ext_trig_sel,
   input  wire logic [2:0] chan_sel,
   input  wire logic [1:0] ext_input_sel,
   input  wire logic [1:0] sweep_sel,
   input  wire logic       prec_10bit,
   input  wire logic       sample_hold_en,
   input  wire logic [1:0] clk_div_sel,
   input  wire logic       ref_connect,
   input  wire logic       external_conv_trigger,
   input  wire logic       cmp_above,
   input  wire logic [4:0] rd_addr,
   output logic [7:0]      rd_data,
   output logic            start_flag,
   output logic            busy,
   output logic            conv_done_irq,
   output logic [3:0]      mux_sel,
   output logic [9:0]      dac_code,
   output logic            ref_ladder_on,
   output logic            sample_phase
);
   typedef enum logic [1:0] {
      sadc_st_idle = 2'b00,
      sadc_st_conv = 2'b01
   } sadc_state_t;

   sadc_state_t          st_ff;
   sadc_pkg::sadc_mode_t mode_ff;
   logic       flag_ff;
   logic       ext_ff;
   logic       prec_ff;
   logic       sh_ff;
   logic       ref_ff;
   logic [1:0] div_cnt_ff;
   logic       trig_s1_ff;
   logic       trig_s2_ff;
   logic       trig_s3_ff;
   logic [3:0] ch_ff;
   logic [3:0] first_ff;
   logic [3:0] last_ff;
   logic       core_go_ff;
   logic       irq_ff;
   logic [7:0] rd_ff;
   logic [7:0] lo_ff [CH_N];
   logic [1:0] hi_ff [CH_N];
   logic       phi_tick;
   logic       ext_fall;
   logic       sw_rise;
   logic       go;
   logic       stop;
   logic       finish;
   logic       cont;
   logic       auto_clr;
   logic       nxt_flag;
   logic       is_repeat;
   logic       is_single;
   logic [3:0] sel_ch;
   logic [3:0] nxt_first;
   logic [3:0] nxt_last;
   logic       core_busy;
   logic       core_done;
   logic [9:0] core_res;
   logic       wr_res;

   // ---------------------------------------------
   // converter clock divider
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         div_cnt_ff <= 2'h0;
      end else begin
         div_cnt_ff <= div_cnt_ff + 2'h1;
      end
   end

   // a tick strobe rather than a divided clock keeps one clock domain
   always_comb begin
      case (clk_div_sel)
         sadc_pkg::DIV_1: phi_tick = 1'b1;
         sadc_pkg::DIV_2: phi_tick = div_cnt_ff[0];
         sadc_pkg::DIV_4: phi_tick = (div_cnt_ff == 2'h3);
         default:         phi_tick = (div_cnt_ff == 2'h3);
      endcase
   end

   // ---------------------------------------------
   // reference ladder switch
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         ref_ff <= 1'b0;
      end else begin
         ref_ff <= ref_connect;
      end
   end

   // ---------------------------------------------
   // trigger pin synchroniser
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         trig_s1_ff <= 1'b1;
         trig_s2_ff <= 1'b1;
         trig_s3_ff <= 1'b1;
      end else begin
         trig_s1_ff <= external_conv_trigger;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
      end
   end

   assign ext_fall = trig_s3_ff && !trig_s2_ff;

   // ---------------------------------------------
   // start conditions
   // ---------------------------------------------
   assign sw_rise = start_wr && start_wdata && !flag_ff && !ext_trig_sel;
   assign go      = sw_rise || (ext_trig_sel && flag_ff && ext_fall && !stop);
   assign stop    = start_wr && !start_wdata;

   // ---------------------------------------------
   // channel selection
   // ---------------------------------------------
   always_comb begin
      case (ext_input_sel)
         sadc_pkg::EXT_A: sel_ch = sadc_pkg::CH_EXT_A;
         sadc_pkg::EXT_B: sel_ch = sadc_pkg::CH_EXT_B;
         default:         sel_ch = {1'b0, chan_sel};
      endcase
   end

   assign is_single = (mode_sel == sadc_pkg::sadc_one_shot) || (mode_sel == sadc_pkg::sadc_repeat);
   assign nxt_first = is_single ? sel_ch : 4'h0;
   assign nxt_last  = is_single ? sel_ch : {1'b0, sweep_sel, 1'b1};
   assign is_repeat = (mode_ff != sadc_pkg::sadc_one_shot) && (mode_ff != sadc_pkg::sadc_sweep);

   // ---------------------------------------------
   // end of a channel
   // ---------------------------------------------
   // a restart already launched makes the finishing result stale
   assign wr_res = core_done && (st_ff == sadc_st_conv) && !go && !stop && !core_go_ff;
   assign cont   = wr_res && ((ch_ff != last_ff) || is_repeat);
   assign finish = wr_res && (ch_ff == last_ff) && !is_repeat;
   assign auto_clr = finish && !ext_ff;

   // ---------------------------------------------
   // start flag
   // ---------------------------------------------
   // a software write beats the automatic clear in the same cycle
   always_comb begin
      if (start_wr) begin
         nxt_flag = start_wdata;
      end else if (auto_clr) begin
         nxt_flag = 1'b0;
      end else begin
         nxt_flag = flag_ff;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // ---------------------------------------------
   // sequence state
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         st_ff      <= sadc_st_idle;
         mode_ff    <= sadc_pkg::sadc_one_shot;
         ext_ff     <= 1'b0;
         prec_ff    <= 1'b0;
         sh_ff      <= 1'b0;
         ch_ff      <= 4'h0;
         first_ff   <= 4'h0;
         last_ff    <= 4'h0;
         core_go_ff <= 1'b0;
      end else begin
         core_go_ff <= go || cont;
         case (st_ff)
            sadc_st_idle: begin
               if (go) begin
                  st_ff    <= sadc_st_conv;
                  mode_ff  <= sadc_pkg::sadc_mode_t'(mode_sel);
                  ext_ff   <= ext_trig_sel;
                  prec_ff  <= prec_10bit;
                  sh_ff    <= sample_hold_en;
                  ch_ff    <= nxt_first;
                  first_ff <= nxt_first;
                  last_ff  <= nxt_last;
               end
            end
            sadc_st_conv: begin
               if (stop || !flag_ff) begin
                  st_ff <= sadc_st_idle;
               end else if (go) begin
                  ch_ff <= first_ff;
               end else if (finish) begin
                  st_ff <= sadc_st_idle;
               end else if (cont) begin
                  ch_ff <= (ch_ff == last_ff) ? first_ff : ch_ff + 4'h1;
               end
            end
            default: begin
               st_ff <= sadc_st_idle;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // completion request
   // ---------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= finish;
      end
   end

   // ---------------------------------------------
   // shared converter
   // ---------------------------------------------
   sadc_sar_core u_core (
      .clock          (clock),
      .rst            (rst),
      .phi_tick       (phi_tick),
      .start          (core_go_ff),
      .abort          (stop),
      .prec_10bit     (prec_ff),
      .sample_hold_en (sh_ff),
      .cmp_above      (cmp_above),
      .dac_code       (dac_code),
      .busy           (core_busy),
      .sampling       (sample_phase),
      .done           (core_done),
      .result         (core_res)
   );

   // ---------------------------------------------
   // result registers
   // ---------------------------------------------
   for (genvar i = 0; i < CH_N; i++) begin : g_res
      always_ff @(posedge clock) begin
         if (rst) begin
            lo_ff[i] <= 8'h00;
            hi_ff[i] <= 2'h0;
         end else if (wr_res && (ch_ff == 4'(i))) begin
            lo_ff[i] <= core_res[7:0];
            if (prec_ff) begin
               hi_ff[i] <= core_res[9:8];
            end
         end
      end

      chk_odd_untouched: assert property (@(posedge clock) disable iff (rst)
         wr_res && !prec_ff |=> $stable(hi_ff[i]))
         else $error("8-bit result changed an odd byte");
      chk_split_bytes: assert property (@(posedge clock) disable iff (rst)
         wr_res && prec_ff && ch_ff == 4'(i)
         |=> lo_ff[i] == $past(core_res[7:0]) && hi_ff[i] == $past(core_res[9:8]))
         else $error("10-bit result not split into even and odd bytes");
   end

   // odd byte holds the top two bits, the rest reads as zero
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_ff <= 8'h00;
      end else if (32'(rd_addr[4:1]) >= CH_N) begin
         rd_ff <= 8'h00;
      end else if (rd_addr[0]) begin
         rd_ff <= {6'h00, hi_ff[rd_addr[4:1]]};
      end else begin
         rd_ff <= lo_ff[rd_addr[4:1]];
      end
   end

   assign rd_data       = rd_ff;
   assign start_flag    = flag_ff;
   assign busy          = (st_ff == sadc_st_conv);
   assign conv_done_irq = irq_ff;
   assign mux_sel       = ch_ff;
   assign ref_ladder_on = ref_ff;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_ladder_off: assert property (!ref_connect |=> !ref_ladder_on)
      else $error("ladder connected without the connect bit");
   chk_div_quarter: assert property (
      clk_div_sel == sadc_pkg::DIV_4 && $stable(clk_div_sel) && phi_tick |-> !$past(phi_tick))
      else $error("quartered converter clock ticks twice in a row");
   chk_sw_start: assert property (sw_rise |=> core_go_ff ##1 core_busy)
      else $error("software start did not launch the converter");
   chk_ext_restart: assert property (
      ext_trig_sel && flag_ff && ext_fall && !stop |=> core_go_ff && ch_ff == first_ff)
      else $error("trigger edge did not restart the conversion");
   chk_stop_idle: assert property (stop |=> st_ff == sadc_st_idle && !core_busy)
      else $error("clearing the start flag did not stop conversion");
   chk_end_request: assert property (
      wr_res && mode_ff == sadc_pkg::sadc_one_shot |=> conv_done_irq && !busy)
      else $error("one-shot end gave no completion request");
   chk_flag_clear: assert property (
      conv_done_irq && !ext_ff && !$past(start_wr) |-> !start_flag)
      else $error("start flag not cleared at the end of conversion");
   chk_repeat_quiet: assert property (mode_ff == sadc_pkg::sadc_repeat |=> !conv_done_irq)
      else $error("repeat mode raised a completion request");
   chk_sweep_order: assert property (
      cont && ch_ff != last_ff |=> ch_ff == $past(ch_ff) + 4'h1)
      else $error("sweep did not step to the next channel");

   cov_one_shot: cover property (conv_done_irq && mode_ff == sadc_pkg::sadc_one_shot);
   cov_sweep_end: cover property (
      conv_done_irq && mode_ff == sadc_pkg::sadc_sweep && last_ff == 4'h7);
   cov_retrigger: cover property (ext_fall && flag_ff && ext_trig_sel && core_busy);
endmodule : sadc_sequencer

// >>> sadc_analog_model.sv
module sadc_analog_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [3:0] mux_sel,
   input  wire logic [9:0] dac_code,
   input  wire logic       ref_ladder_on,
   output logic            cmp_above
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       flip_ff;
   logic [9:0] level;

   // -----------------------------------
   // ten inputs, eight primary and two extended
   // -----------------------------------
   always_comb level = 10'h05A + 10'h067 * {6'h00, mux_sel};

   always_ff @(posedge clock) begin
      if (rst) flip_ff <= 1'b0;
      else flip_ff <= ~flip_ff;
   end

   // ladder off or bad select: output is noise, so toggle rather than hold
   assign cmp_above = (ref_ladder_on && mux_sel < 4'hA) ? (level >= dac_code) : flip_ff;
endmodule : sadc_analog_model

// >>> test_sar_adc_sequencer.sv
module test_sar_adc_sequencer;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock, rst, start_wr, start_wdata, ext_trig_sel, prec_10bit, sample_hold_en;
   logic ref_connect, external_conv_trigger, cmp_above, start_flag, busy, conv_done_irq;
   logic ref_ladder_on, sample_phase;
   logic [2:0] mode_sel, chan_sel;
   logic [1:0] ext_input_sel, sweep_sel, clk_div_sel;
   logic [4:0] rd_addr;
   logic [7:0] rd_data;
   logic [3:0] mux_sel;
   logic [9:0] dac_code;
   int         err_count = 0;
   int         checks = 0;

   sadc_sequencer #(.CH_N(sadc_pkg::CH_N)) i_sadc_sequencer (
      .clock(clock), .rst(rst), .start_wr(start_wr), .start_wdata(start_wdata),
      .mode_sel(mode_sel), .ext_trig_sel(ext_trig_sel), .chan_sel(chan_sel),
      .ext_input_sel(ext_input_sel), .sweep_sel(sweep_sel), .prec_10bit(prec_10bit),
      .sample_hold_en(sample_hold_en), .clk_div_sel(clk_div_sel), .ref_connect(ref_connect),
      .external_conv_trigger(external_conv_trigger), .cmp_above(cmp_above),
      .rd_addr(rd_addr), .rd_data(rd_data), .start_flag(start_flag), .busy(busy),
      .conv_done_irq(conv_done_irq), .mux_sel(mux_sel), .dac_code(dac_code),
      .ref_ladder_on(ref_ladder_on), .sample_phase(sample_phase));
   sadc_analog_model i_sadc_analog_model (.clock(clock), .rst(rst), .mux_sel(mux_sel),
      .dac_code(dac_code), .ref_ladder_on(ref_ladder_on), .cmp_above(cmp_above));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   function automatic logic [9:0] vin(input logic [3:0] ch);
      return 10'h05A + 10'h067 * {6'h00, ch};
   endfunction : vin

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("errors=%0d checks=%0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic write_flag(input logic v);
      @(negedge clock);
      start_wr = 1'b1;
      start_wdata = v;
      @(negedge clock);
      start_wr = 1'b0;
   endtask : write_flag

   task automatic read_entry(input logic [3:0] ch, output logic [15:0] val);
      @(negedge clock);
      rd_addr = {ch, 1'b0};
      @(negedge clock);
      val[7:0] = rd_data;
      rd_addr = {ch, 1'b1};
      @(negedge clock);
      val[15:8] = rd_data;
   endtask : read_entry

   task automatic wait_irq(output int n, output int sp);
      n = 0;
      sp = 0;
      while (conv_done_irq !== 1'b1 && n < 4000) begin
         @(negedge clock);
         n++;
         if (sample_phase === 1'b1) sp++;
      end
   endtask : wait_irq

   task automatic one_shot(input logic [3:0] ch, input logic p10, input logic sh,
                           input logic [1:0] dv, input logic [15:0] exp_rd);
      int          n, sp, len, d, nb;
      logic [15:0] r;
      mode_sel = sadc_pkg::sadc_one_shot;
      chan_sel = ch[2:0];
      ext_input_sel = (ch == 4'h8) ? sadc_pkg::EXT_A :
                      (ch == 4'h9) ? sadc_pkg::EXT_B : sadc_pkg::EXT_NONE;
      prec_10bit = p10;
      sample_hold_en = sh;
      clk_div_sel = dv; // quarter of 125 MHz stays far above 1 MHz
      len = sh ? (p10 ? sadc_pkg::CYC_10_SH : sadc_pkg::CYC_8_SH)
               : (p10 ? sadc_pkg::CYC_10_PLAIN : sadc_pkg::CYC_8_PLAIN);
      nb = p10 ? sadc_pkg::BITS_10 : sadc_pkg::BITS_8;
      d = 1 << dv;
      write_flag(1'b1);
      wait_irq(n, sp);
      check({15'h0000, n >= (len - 1) * d + 3 && n <= len * d + 2}, 16'h0001);
      if (d == 1) check(sp[15:0], 16'(len - nb));
      check({14'h0000, start_flag, busy}, 16'h0000);
      read_entry(ch, r);
      check(r, exp_rd);
   endtask : one_shot

   task automatic test_one_shot();
      logic [9:0] v;
      v = vin(4'h5);
      one_shot(4'h5, 1'b1, 1'b0, sadc_pkg::DIV_1, {6'h00, v});
      one_shot(4'h5, 1'b0, 1'b0, sadc_pkg::DIV_1, {6'h00, v[9:8], v[9:2]});
      one_shot(4'h5, 1'b1, 1'b1, sadc_pkg::DIV_2, {6'h00, v});
      one_shot(4'h5, 1'b0, 1'b1, sadc_pkg::DIV_4, {6'h00, v[9:8], v[9:2]});
      v = vin(4'h8);
      one_shot(4'h8, 1'b1, 1'b1, sadc_pkg::DIV_1, {6'h00, v});
      v = vin(4'h9);
      one_shot(4'h9, 1'b1, 1'b1, sadc_pkg::DIV_1, {6'h00, v});
      ext_input_sel = sadc_pkg::EXT_NONE;
   endtask : test_one_shot

   task automatic test_looping();
      logic        irq_seen;
      logic [15:0] r;
      sadc_pkg::sadc_mode_t modes[3];
      modes = '{sadc_pkg::sadc_repeat, sadc_pkg::sadc_rsweep0, sadc_pkg::sadc_rsweep1};
      foreach (modes[i]) begin
         mode_sel = modes[i];
         {chan_sel, sweep_sel, prec_10bit, sample_hold_en} = {3'h3, 2'h1, 1'b1, 1'b1};
         clk_div_sel = sadc_pkg::DIV_1;
         irq_seen = 1'b0;
         write_flag(1'b1);
         repeat (300) begin
            @(negedge clock);
            irq_seen = irq_seen | conv_done_irq;
         end
         check({15'h0000, busy}, 16'h0001);
         check({15'h0000, irq_seen}, 16'h0000);
         write_flag(1'b0);
         @(negedge clock);
         check({14'h0000, start_flag, busy}, 16'h0000);
         read_entry(4'h3, r);
         check(r, {6'h00, vin(4'h3)});
      end
   endtask : test_looping

   task automatic test_sweep();
      logic [3:0]  k, prev;
      logic [15:0] r;
      int          n;
      for (int s = 0; s < 4; s++) begin
         mode_sel = sadc_pkg::sadc_sweep;
         {sweep_sel, prec_10bit, sample_hold_en} = {s[1:0], 1'b0, 1'b1};
         k = 4'h0;
         prev = 4'hF;
         n = 0;
         write_flag(1'b1);
         while (conv_done_irq !== 1'b1 && n < 4000) begin
            @(negedge clock);
            n++;
            if (busy === 1'b1 && mux_sel !== prev) begin
               check({12'h000, mux_sel}, {12'h000, k});
               prev = mux_sel;
               k++;
            end
         end
         check({12'h000, k}, 16'h0002 + 16'h0002 * s[15:0]);
         check({14'h0000, start_flag, busy}, 16'h0000);
         for (int c = 0; c < 2 * s + 2; c++) begin
            read_entry(c[3:0], r);
            check({8'h00, r[7:0]}, {8'h00, 8'(vin(c[3:0]) >> 2)});
         end
      end
   endtask : test_sweep

   task automatic test_ext_trig();
      logic [15:0] r;
      int          n, sp;
      {mode_sel, chan_sel, prec_10bit, sample_hold_en} = {3'h0, 3'h6, 1'b1, 1'b0};
      ext_trig_sel = 1'b1;
      write_flag(1'b1);
      repeat (10) @(negedge clock);
      check({14'h0000, start_flag, busy}, 16'h0002);
      external_conv_trigger = 1'b0;
      repeat (20) @(negedge clock);
      external_conv_trigger = 1'b1;
      repeat (5) @(negedge clock);
      external_conv_trigger = 1'b0; // retrigger mid conversion
      wait_irq(n, sp);
      check({15'h0000, n >= 62 && n <= 70}, 16'h0001);
      check({14'h0000, start_flag, busy}, 16'h0002);
      read_entry(4'h6, r);
      check(r, {6'h00, vin(4'h6)});
      external_conv_trigger = 1'b1;
      ext_trig_sel = 1'b0;
      write_flag(1'b0);
   endtask : test_ext_trig

   task automatic test_ref();
      @(negedge clock);
      ref_connect = 1'b0;
      repeat (2) @(negedge clock);
      check({15'h0000, ref_ladder_on}, 16'h0000);
      ref_connect = 1'b1;
      repeat (2) @(negedge clock);
      check({15'h0000, ref_ladder_on}, 16'h0001);
   endtask : test_ref

   // -----------------------------------
   // main sequence
   // -----------------------------------
   initial begin
      {rst, start_wr, start_wdata, ext_trig_sel} = 4'h8;
      {mode_sel, chan_sel, ext_input_sel, sweep_sel} = 10'h000;
      {prec_10bit, sample_hold_en, clk_div_sel} = 4'h0;
      ref_connect = 1'b1; // analog pins taken as inputs already
      external_conv_trigger = 1'b1;
      rd_addr = 5'h00;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      test_ref();
      test_one_shot();
      test_looping();
      test_sweep();
      test_ext_trig();
      end_of_test();
   end

   // generous bound, whole run needs well under 10k cycles
   initial begin
      repeat (32'h0000_C350) @(posedge clock);
      err_count++;
      end_of_test();
   end
endmodule : test_sar_adc_sequencer
